//--- inc/fpsru_consts.svh
// Constants for the floating-point store, select and rounding unit.
// Included by the design files; holds definitions only.
`ifndef FPSRU_CONSTS_SVH
`define FPSRU_CONSTS_SVH

// Internal rounding codes; the low two match the status/control field
`define FPSRU_RM_RNE   3'h0
`define FPSRU_RM_RP    3'h1
`define FPSRU_RM_RM    3'h2
`define FPSRU_RM_RZ    3'h3
`define FPSRU_RM_RNA   3'h4

// Select conditions
`define FPSRU_CC_EQ    2'h0
`define FPSRU_CC_VS    2'h1
`define FPSRU_CC_GE    2'h2
`define FPSRU_CC_GT    2'h3

// Store offset is a word count, scaled to bytes
`define FPSRU_OFS_SHIFT 2

// Format geometry
`define FPSRU_SP_EW    8
`define FPSRU_SP_MW    23
`define FPSRU_DP_EW    11
`define FPSRU_DP_MW    52

`endif

//--- inc/fpsru_pkg.sv
// Types shared by the floating-point store, select and rounding unit.
// No assumptions beyond a SystemVerilog compiler.
package fpsru_pkg;

  typedef enum logic [3:0] {
    FPSRU_STORE      = 4'h0,
    FPSRU_SUB        = 4'h1,
    FPSRU_SEL        = 4'h2,
    FPSRU_MAXNM      = 4'h3,
    FPSRU_MINNM      = 4'h4,
    FPSRU_CVT        = 4'h5,
    FPSRU_RINT_MODE  = 4'h6,
    FPSRU_RINT_EXACT = 4'h7,
    FPSRU_RINT_DIR   = 4'h8
  } fpsru_kind_t;

  typedef struct packed {
    logic        valid;
    fpsru_kind_t kind;
    logic        dbl;
    logic [2:0]  rmode;
    logic [1:0]  cond;
    logic        add_off;
    logic [7:0]  imm_words;
    logic        to_signed;
  } fpsru_op_t;

  typedef struct packed {logic n; logic z; logic c; logic v;} fpsru_flags_t;

  typedef struct packed {logic valid; logic dbl; logic [63:0] data;} fpsru_wb_t;

  typedef struct packed {
    logic        valid;
    logic        dbl;
    logic [31:0] addr;
    logic [63:0] data;
  } fpsru_st_t;

  typedef struct packed {logic inexact; logic invalid;} fpsru_exc_t;

  typedef struct packed {
    logic [63:0] diff;
    logic [63:0] max;
    logic [63:0] min;
    logic [63:0] rint;
    logic [31:0] intv;
    logic        diff_inx;
    logic        diff_inv;
    logic        mm_inv;
    logic        rint_inx;
    logic        int_inx;
    logic        int_inv;
  } fpsru_res_t;

  typedef struct packed {fpsru_wb_t wb; fpsru_st_t st; fpsru_exc_t exc;} fpsru_state_t;

endpackage

//--- logic/fpsru_fmt.sv
// Combinational arithmetic for one floating-point format: subtract,
// max/min number, round to integral and conversion to 32-bit integer.
// Assumes the caller picks the rounding mode; results are zero-extended.
`timescale 1ns/1ps
`include "fpsru_consts.svh"
module fpsru_fmt
  import fpsru_pkg::*;
#(
  parameter int EW = `FPSRU_SP_EW,
  parameter int MW = `FPSRU_SP_MW
) (
  input  wire logic [EW+MW:0] a_in,
  input  wire logic [EW+MW:0] b_in,
  input  wire logic [2:0]     rmode_in,
  input  wire logic           to_signed_in,
  output fpsru_res_t          res_out
);

  localparam int             W     = EW + MW + 1;
  localparam logic [EW-1:0]  EONES = '1;
  localparam logic [EW-1:0]  BIAS  = {1'b0, {(EW-1){1'b1}}};
  localparam logic [W-1:0]   QNAN  = {1'b0, EONES, 1'b1, {(MW-1){1'b0}}};

  function automatic logic is_nan(input logic [W-1:0] x);
    return (x[W-2:MW] == EONES) && (x[MW-1:0] != '0);
  endfunction

  function automatic logic is_snan(input logic [W-1:0] x);
    return is_nan(x) && !x[MW-1];
  endfunction

  // Maps a value onto an unsigned key whose order is numeric order
  function automatic logic [W-1:0] order_key(input logic [W-1:0] x);
    return x[W-1] ? ~x : {1'b1, x[W-2:0]};
  endfunction

  function automatic logic round_up(input logic [2:0] rm, input logic sgn,
                                    input logic lsb, input logic g, input logic s);
    logic r;
    r = 1'b0;
    unique case (rm)
      `FPSRU_RM_RNE: r = g & (s | lsb);
      `FPSRU_RM_RP:  r = !sgn & (g | s);
      `FPSRU_RM_RM:  r = sgn & (g | s);
      `FPSRU_RM_RNA: r = g;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction

  logic [W-1:0]           mx;
  logic [W-1:0]           mn;
  logic [W-1:0]           rint;
  logic [W-1:0]           diff;
  logic                   sgn_a;
  logic [EW-1:0]          ex_a;
  logic [MW:0]            sig_a;
  logic signed [EW+1:0]   e_a;
  int                     fb;
  logic [MW+2:0]          sx;
  logic [MW+2:0]          rsh;
  logic                   g_a;
  logic                   s_a;
  logic [MW+1:0]          ir;
  logic [MW+1:0]          rsig;
  logic [63:0]            mag;
  logic                   big;
  logic [W-1:0]           bn;
  logic [W-1:0]           xl;
  logic [W-1:0]           xs;
  logic [EW-1:0]          el;
  logic [EW-1:0]          es;
  logic [EW-1:0]          dexp;
  logic [MW+3:0]          ml;
  logic [MW+3:0]          ms;
  logic [MW+3:0]          msh;
  logic [MW+4:0]          sum;
  logic [EW:0]            er;
  logic [EW:0]            fld;
  logic [MW+1:0]          man;
  logic                   sub_inc;
  logic                   tz;
  logic                   mm_inv;
  logic                   rint_inx;
  logic [31:0]            intv;
  logic                   int_inx;
  logic                   int_inv;
  logic                   diff_inx;
  logic                   diff_inv;

  // ---------------------------------------------------------------
  // Max/min number
  // ---------------------------------------------------------------
  always_comb
  begin
    mm_inv = is_snan(a_in) | is_snan(b_in);
    // A quiet NaN loses to a number; signalling NaN gives default NaN [RQ11] [RQ18]
    if (mm_inv || (is_nan(a_in) && is_nan(b_in)))
    begin
      mx = QNAN;
      mn = QNAN;
    end
    else if (is_nan(a_in))
    begin
      mx = b_in;
      mn = b_in;
    end
    else if (is_nan(b_in))
    begin
      mx = a_in;
      mn = a_in;
    end
    else if (order_key(a_in) >= order_key(b_in)) // [RQ10]
    begin
      mx = a_in;
      mn = b_in;
    end
    else
    begin
      mx = b_in;
      mn = a_in;
    end
  end

  // ---------------------------------------------------------------
  // Round to integral and to integer
  // ---------------------------------------------------------------
  always_comb
  begin
    sgn_a = a_in[W-1];
    ex_a  = a_in[W-2:MW];
    sig_a = {ex_a != '0, a_in[MW-1:0]};
    e_a   = $signed({2'b00, ex_a}) - $signed({2'b00, BIAS});
    if (e_a < -1)
      fb = MW + 2;
    else if (e_a >= MW)
      fb = 0;
    else
      fb = MW - int'(e_a);
    sx   = {sig_a, 2'b00};
    rsh  = sx >> fb;
    g_a  = rsh[1];
    s_a  = rsh[0] | ((sx & ~({(MW+3){1'b1}} << fb)) != '0);
    ir   = {1'b0, rsh[MW+2:2]}
         + {{(MW+1){1'b0}}, round_up(rmode_in, sgn_a, rsh[2], g_a, s_a)};
    rsig = ir << fb;
    big  = (ex_a == EONES) || (e_a >= 32);
    if (e_a >= MW)
      mag = (e_a >= 32) ? 64'h0 : 64'(sig_a) << (int'(e_a) - MW);
    else
      mag = 64'(ir);

    rint_inx = 1'b0;
    if (ex_a == EONES)
      rint = is_nan(a_in) ? (a_in | QNAN) : a_in;
    else if (e_a >= MW)
      rint = a_in;
    else
    begin
      rint_inx = g_a | s_a;
      if (ir == '0)
        rint = {sgn_a, {(W-1){1'b0}}};
      else if (e_a < 0 || rsig[MW+1])
        rint = {sgn_a, ((e_a < 0) ? BIAS : EW'(ex_a + 1'b1)), {MW{1'b0}}};
      else
        rint = {sgn_a, ex_a, rsig[MW-1:0]};
    end

    // Out-of-range values saturate and raise invalid [RQ12]
    int_inx = 1'b0;
    int_inv = 1'b0;
    if (is_nan(a_in))
    begin
      intv    = 32'h0;
      int_inv = 1'b1;
    end
    else if (to_signed_in)
    begin
      if (big || mag > (sgn_a ? 64'h80000000 : 64'h7fffffff))
      begin
        intv    = sgn_a ? 32'h80000000 : 32'h7fffffff;
        int_inv = 1'b1;
      end
      else
      begin
        intv    = sgn_a ? (~mag[31:0] + 32'h1) : mag[31:0];
        int_inx = g_a | s_a;
      end
    end
    else if (sgn_a && (big || mag != 64'h0))
    begin
      intv    = 32'h0;
      int_inv = 1'b1;
    end
    else if (!sgn_a && (big || mag > 64'hffffffff))
    begin
      intv    = 32'hffffffff;
      int_inv = 1'b1;
    end
    else
    begin
      intv    = mag[31:0];
      int_inx = g_a | s_a;
    end
  end

  // ---------------------------------------------------------------
  // Subtract: add of the negated second operand
  // ---------------------------------------------------------------
  always_comb
  begin
    bn = {~b_in[W-1], b_in[W-2:0]};
    if (a_in[W-2:0] >= bn[W-2:0])
    begin
      xl = a_in;
      xs = bn;
    end
    else
    begin
      xl = bn;
      xs = a_in;
    end
    el   = (xl[W-2:MW] == '0) ? EW'(1) : xl[W-2:MW];
    es   = (xs[W-2:MW] == '0) ? EW'(1) : xs[W-2:MW];
    ml   = {xl[W-2:MW] != '0, xl[MW-1:0], 3'b000};
    ms   = {xs[W-2:MW] != '0, xs[MW-1:0], 3'b000};
    dexp = el - es;
    if (dexp > EW'(MW + 3))
      msh = {{(MW+3){1'b0}}, ms != '0};
    else
      msh = (ms >> dexp) | {{(MW+3){1'b0}}, (ms & ~({(MW+4){1'b1}} << dexp)) != '0};
    sum = (xl[W-1] == xs[W-1]) ? {1'b0, ml} + {1'b0, msh} : {1'b0, ml} - {1'b0, msh};
    er  = {1'b0, el};
    if (sum[MW+4])
    begin
      sum = {1'b0, sum[MW+4:2], sum[1] | sum[0]};
      er  = er + 1'b1;
    end
    // Stops at the smallest exponent, leaving a subnormal unnormalised
    for (int i = 0; i < MW + 4; i++)
    begin
      if (!sum[MW+3] && er > 1)
      begin
        sum = sum << 1;
        er  = er - 1'b1;
      end
    end
    sub_inc = round_up(rmode_in, xl[W-1], sum[3], sum[2], sum[1:0] != 2'b00);
    man = {1'b0, sum[MW+3:3]} + {{(MW+1){1'b0}}, sub_inc};
    fld = man[MW+1] ? er + 1'b1 : (man[MW] ? er : '0);
    tz  = rmode_in == `FPSRU_RM_RZ || (rmode_in == `FPSRU_RM_RP && xl[W-1])
       || (rmode_in == `FPSRU_RM_RM && !xl[W-1]);

    diff_inx = 1'b0;
    diff_inv = 1'b0;
    if (is_nan(a_in) || is_nan(b_in))
    begin
      diff             = QNAN;
      diff_inv = is_snan(a_in) | is_snan(b_in);
    end
    else if (xl[W-2:MW] == EONES)
    begin
      diff_inv = xs[W-2:MW] == EONES && xl[W-1] != xs[W-1];
      diff     = diff_inv ? QNAN : xl;
    end
    else if (sum == '0)
      diff = {(xl[W-1] == xs[W-1]) ? xl[W-1] : rmode_in == `FPSRU_RM_RM, {(W-1){1'b0}}};
    else if (fld >= {1'b0, EONES})
    begin
      diff_inx = 1'b1;
      diff = tz ? {xl[W-1], EW'(EONES - 1'b1), {MW{1'b1}}} : {xl[W-1], EONES, {MW{1'b0}}};
    end
    else
    begin
      diff             = {xl[W-1], fld[EW-1:0], man[MW-1:0]}; // [RQ5]
      diff_inx = sum[2] | (sum[1:0] != 2'b00);
    end
  end

  // One driver for the whole result word
  assign res_out = '{diff: 64'(diff), max: 64'(mx), min: 64'(mn), rint: 64'(rint),
                     intv: intv, diff_inx: diff_inx, diff_inv: diff_inv, mm_inv: mm_inv,
                     rint_inx: rint_inx, int_inx: int_inx, int_inv: int_inv};

endmodule

//--- logic/fpsru_top.sv
// Floating-point store, subtract, select, max/min, conversion and
// round-to-integral unit with one registered result stage.
// Assumes the pipeline presents decoded operations with operands and
// holds the condition-pass verdict for conditional operations.
//
// Summary of operation
// RQ1: Store address is base plus or minus a word offset up to 1020.
// RQ2: Store writes exactly one single or double extension register.
// RQ3: Stack pointer is a legal store base; program counter is deprecated.
// RQ4: Store size qualifier 32 or 64 picks single or double source.
// RQ5: Subtract puts first operand minus second into the destination.
// RQ6: No operation here changes the N, Z, C or V flags.
// RQ7: Select accepts only GE, GT, EQ and VS conditions.
// RQ8: Select copies first source if condition holds, else second.
// RQ9: Software keeps select out of conditional-execution blocks.
// RQ10: Maximum writes the larger source, minimum the smaller.
// RQ11: Max/min handle NaN inputs as the 2008 standard requires.
// RQ12: Directed conversion to 32-bit signed or unsigned integer, four modes.
// RQ13: Mode-controlled integral rounding uses the status/control rounding mode.
// RQ14: Exact-checking integral rounding raises inexact when result differs.
// RQ15: Directed integral rounding uses the encoded mode, five modes.
// RQ16: Directed integral rounding never raises inexact.
// RQ17: Directed integral rounding always executes unconditionally.
// RQ18: One quiet NaN against a number returns the number.
`timescale 1ns/1ps
`include "fpsru_consts.svh"
module fpsru_top
  import fpsru_pkg::*;
(
  input  wire logic         REF_CLK_IN,
  input  wire logic         RST_N_IN,
  input  wire fpsru_op_t    OP_IN,
  input  wire logic [63:0]  OPA_IN,
  input  wire logic [63:0]  OPB_IN,
  input  wire logic [31:0]  BASE_IN,
  input  wire fpsru_flags_t FLAGS_IN,
  input  wire logic [1:0]   STATUS_RM_IN,
  input  wire logic         COND_PASS_IN,
  output fpsru_wb_t         WB_OUT,
  output fpsru_st_t         ST_OUT,
  output fpsru_exc_t        EXC_OUT
);

  fpsru_state_t st_reg;
  fpsru_state_t st_next;
  fpsru_res_t   sp_res;
  fpsru_res_t   dp_res;
  fpsru_res_t   res;
  logic [2:0]   rm;
  logic         exec;
  logic [31:0]  off;
  logic [63:0]  src_a;
  logic [63:0]  src_b;

  // Only four conditions are encodable, so the inverses need swapped sources [RQ7]
  function automatic logic sel_cond(input logic [1:0] cc, input fpsru_flags_t f);
    logic r;
    r = 1'b0;
    unique case (cc)
      `FPSRU_CC_EQ: r = f.z;
      `FPSRU_CC_VS: r = f.v;
      `FPSRU_CC_GE: r = f.n == f.v;
      `FPSRU_CC_GT: r = !f.z && (f.n == f.v);
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Format datapaths
  // ---------------------------------------------------------------
  fpsru_fmt #(
    .EW (`FPSRU_SP_EW),
    .MW (`FPSRU_SP_MW)
  ) u_sp (
    .a_in         (OPA_IN[31:0]),
    .b_in         (OPB_IN[31:0]),
    .rmode_in     (rm),
    .to_signed_in (OP_IN.to_signed),
    .res_out      (sp_res)
  );

  fpsru_fmt #(
    .EW (`FPSRU_DP_EW),
    .MW (`FPSRU_DP_MW)
  ) u_dp (
    .a_in         (OPA_IN),
    .b_in         (OPB_IN),
    .rmode_in     (rm),
    .to_signed_in (OP_IN.to_signed),
    .res_out      (dp_res)
  );

  // ---------------------------------------------------------------
  // Operation dispatch
  // ---------------------------------------------------------------
  always_comb
  begin
    // Directed forms carry their own mode; the rest follow status/control
    if (OP_IN.kind == FPSRU_CVT || OP_IN.kind == FPSRU_RINT_DIR) // [RQ12] [RQ15]
      rm = OP_IN.rmode;
    else
      rm = {1'b0, STATUS_RM_IN}; // [RQ13]
    res   = OP_IN.dbl ? dp_res : sp_res;
    src_a = OP_IN.dbl ? OPA_IN : {32'h0, OPA_IN[31:0]};
    src_b = OP_IN.dbl ? OPB_IN : {32'h0, OPB_IN[31:0]};
    // Forms with no condition field ignore the pass verdict [RQ17]
    exec  = OP_IN.valid && (COND_PASS_IN || OP_IN.kind == FPSRU_SEL
          || OP_IN.kind == FPSRU_MAXNM || OP_IN.kind == FPSRU_MINNM
          || OP_IN.kind == FPSRU_CVT || OP_IN.kind == FPSRU_RINT_DIR);
    off   = 32'(OP_IN.imm_words) << `FPSRU_OFS_SHIFT;

    // Results are one-cycle pulses; the unit has no flag write path [RQ6]
    st_next        = '0;
    st_next.wb.dbl = OP_IN.dbl;
    if (exec)
    begin
      unique case (OP_IN.kind)
        FPSRU_STORE:
        begin
          st_next.st.valid = 1'b1; // [RQ2]
          st_next.st.dbl   = OP_IN.dbl; // [RQ4]
          // Any base value is taken, stack pointer included [RQ3]
          st_next.st.addr  = OP_IN.add_off ? BASE_IN + off : BASE_IN - off; // [RQ1]
          st_next.st.data  = src_a;
        end
        FPSRU_SUB:
        begin
          st_next.wb.valid = 1'b1;
          st_next.wb.data  = res.diff; // [RQ5]
          st_next.exc      = '{inexact: res.diff_inx, invalid: res.diff_inv};
        end
        FPSRU_SEL:
        begin
          st_next.wb.valid = 1'b1;
          st_next.wb.data  = sel_cond(OP_IN.cond, FLAGS_IN) ? src_a : src_b; // [RQ8]
        end
        FPSRU_MAXNM, FPSRU_MINNM:
        begin
          st_next.wb.valid       = 1'b1;
          st_next.wb.data        = (OP_IN.kind == FPSRU_MAXNM) ? res.max : res.min; // [RQ10]
          st_next.exc.invalid    = res.mm_inv; // [RQ11]
        end
        FPSRU_CVT:
        begin
          st_next.wb.valid = 1'b1;
          st_next.wb.dbl   = 1'b0;
          st_next.wb.data  = {32'h0, res.intv}; // [RQ12]
          st_next.exc      = '{inexact: res.int_inx, invalid: res.int_inv};
        end
        FPSRU_RINT_MODE, FPSRU_RINT_EXACT, FPSRU_RINT_DIR:
        begin
          st_next.wb.valid   = 1'b1;
          st_next.wb.data    = res.rint;
          // Only the exact-checking form reports inexact [RQ14] [RQ16]
          st_next.exc.inexact = (OP_IN.kind == FPSRU_RINT_EXACT) && res.rint_inx;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign WB_OUT  = st_reg.wb;
  assign ST_OUT  = st_reg.st;
  assign EXC_OUT = st_reg.exc;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [31:0] chk_off;
  logic [31:0] opa_lo;
  logic [31:0] opb_lo;
  logic        go;

  assign chk_off = {22'h0, OP_IN.imm_words, 2'h0};
  assign opa_lo  = OPA_IN[31:0];
  assign opb_lo  = OPB_IN[31:0];
  assign go      = OP_IN.valid && COND_PASS_IN;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  property p_store_addr;
    (go && OP_IN.kind == FPSRU_STORE) |=> ST_OUT.valid && ST_OUT.addr ==
      ($past(OP_IN.add_off) ? $past(BASE_IN) + $past(chk_off)
                            : $past(BASE_IN) - $past(chk_off));
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("store address wrong"); // [RQ1]

  property p_store_one;
    (go && OP_IN.kind == FPSRU_STORE && !OP_IN.dbl) |=> !WB_OUT.valid
      && ST_OUT.data == {32'h0, $past(opa_lo)};
  endproperty
  a_store_one: assert property (p_store_one) else $error("store data wrong"); // [RQ2]

  property p_store_size;
    (go && OP_IN.kind == FPSRU_STORE) |=> ST_OUT.dbl == $past(OP_IN.dbl);
  endproperty
  a_store_size: assert property (p_store_size) else $error("store size wrong"); // [RQ4]

  property p_sub_self;
    (go && OP_IN.kind == FPSRU_SUB && !OP_IN.dbl && opa_lo == opb_lo
      && opa_lo[30:23] != 8'hff) |=> WB_OUT.valid && WB_OUT.data[30:0] == 31'h0;
  endproperty
  a_sub_self: assert property (p_sub_self) else $error("x minus x not zero"); // [RQ5]

  property p_sel_eq;
    (OP_IN.valid && OP_IN.kind == FPSRU_SEL && OP_IN.dbl && OP_IN.cond == `FPSRU_CC_EQ)
      |=> WB_OUT.data == ($past(FLAGS_IN.z) ? $past(OPA_IN) : $past(OPB_IN));
  endproperty
  a_sel_eq: assert property (p_sel_eq) else $error("select picked wrong source"); // [RQ8]

  property p_max_pos;
    (OP_IN.valid && OP_IN.kind == FPSRU_MAXNM && !OP_IN.dbl && !opa_lo[31] && !opb_lo[31]
      && opa_lo[30:23] != 8'hff && opb_lo[30:23] != 8'hff) |=> WB_OUT.data[31:0] ==
      (($past(opa_lo) >= $past(opb_lo)) ? $past(opa_lo) : $past(opb_lo));
  endproperty
  a_max_pos: assert property (p_max_pos) else $error("maximum not largest"); // [RQ10]

  property p_max_qnan;
    (OP_IN.valid && OP_IN.kind == FPSRU_MAXNM && !OP_IN.dbl && opa_lo[30:22] == 9'h1ff
      && opb_lo[30:23] != 8'hff) |=> WB_OUT.data[31:0] == $past(opb_lo) && !EXC_OUT.invalid;
  endproperty
  a_max_qnan: assert property (p_max_qnan) else $error("quiet NaN not ignored"); // [RQ18]

  property p_cvt_neg;
    (OP_IN.valid && OP_IN.kind == FPSRU_CVT && !OP_IN.dbl && !OP_IN.to_signed
      && opa_lo[31] && opa_lo[30:23] >= 8'h7f && opa_lo[30:23] != 8'hff)
      |=> WB_OUT.data[31:0] == 32'h0 && EXC_OUT.invalid;
  endproperty
  a_cvt_neg: assert property (p_cvt_neg) else $error("negative unsigned not zero"); // [RQ12]

  // 1.5 goes down to 1.0 toward zero and toward minus, up to 2.0 otherwise
  property p_rint_status;
    (go && OP_IN.kind == FPSRU_RINT_MODE && !OP_IN.dbl && opa_lo == 32'h3fc00000)
      |=> WB_OUT.data[31:0] == ($past(STATUS_RM_IN[1]) ? 32'h3f800000 : 32'h40000000)
      && !EXC_OUT.inexact;
  endproperty
  a_rint_status: assert property (p_rint_status) else $error("mode not from status"); // [RQ13]

  property p_rint_exact;
    (go && OP_IN.kind == FPSRU_RINT_EXACT && !OP_IN.dbl && opa_lo[30:23] != 8'hff)
      |=> EXC_OUT.inexact == (WB_OUT.data[31:0] != $past(opa_lo));
  endproperty
  a_rint_exact: assert property (p_rint_exact) else $error("inexact mismatch"); // [RQ14]

  property p_rint_dir;
    (OP_IN.valid && OP_IN.kind == FPSRU_RINT_DIR) |=> WB_OUT.valid && !EXC_OUT.inexact;
  endproperty
  a_rint_dir: assert property (p_rint_dir) else $error("directed round misbehaved"); // [RQ16] [RQ17]

  c_store: cover property (go && OP_IN.kind == FPSRU_STORE ##1 ST_OUT.valid);
  c_sel:   cover property (OP_IN.valid && OP_IN.kind == FPSRU_SEL ##1 WB_OUT.valid);
  c_cvt:   cover property (OP_IN.valid && OP_IN.kind == FPSRU_CVT ##1 EXC_OUT.inexact);

endmodule

//--- tb/fpsru_lsu_model.sv
// Load/store side stand-in: takes every store request the unit issues.
// Assumes requests are one-cycle pulses on the core clock.
`timescale 1ns/1ps
module fpsru_lsu_model
  import fpsru_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire fpsru_st_t st_in,
  output fpsru_st_t      last_out,
  output logic [7:0]     count_out
);
  // Counting pulses shows a stray or doubled store that an address check misses
  always_ff @(posedge clk_in)
    if (!rst_n_in)
    begin
      last_out  <= '0;
      count_out <= 8'h0;
    end
    else if (st_in.valid)
    begin
      last_out  <= st_in;
      count_out <= count_out + 8'h1;
    end
endmodule

//--- tb/fpsru_top_bench.sv
// Self-checking bench for the store, select and rounding unit.
// Assumes one registered stage: results one edge after the op is taken.
`timescale 1ns/1ps
module fpsru_top_bench
  import fpsru_pkg::*;
;
  logic         clk;
  logic         rst_n;
  fpsru_op_t    op;
  logic [63:0]  opa;
  logic [63:0]  opb;
  logic [31:0]  base;
  fpsru_flags_t flg;
  logic [1:0]   fpm;
  logic         pass;
  fpsru_wb_t    wb;
  fpsru_st_t    st;
  fpsru_exc_t   exc;
  logic [7:0]   nst;
  int           err_total;
  int           samples_checked;

  fpsru_top dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .OP_IN(op), .OPA_IN(opa), .OPB_IN(opb),
    .BASE_IN(base), .FLAGS_IN(flg), .STATUS_RM_IN(fpm), .COND_PASS_IN(pass), .WB_OUT(wb),
    .ST_OUT(st), .EXC_OUT(exc));
  fpsru_lsu_model lsu (.clk_in(clk), .rst_n_in(rst_n), .st_in(st), .last_out(), .count_out(nst));

  always #50 clk = ~clk;

  // --------------------------------------------------------------
  // Shared drivers and compares
  // --------------------------------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered at a falling edge; returns one falling edge later, result settled.
  // Valid stays up so back-to-back ops never lower and raise it in one step.
  task automatic run(input fpsru_kind_t k, input logic d, input logic [2:0] rm,
                     input logic [63:0] a, input logic [63:0] b);
    op.valid = 1'h1;
    op.kind  = k;
    op.dbl   = d;
    op.rmode = rm;
    opa      = a;
    opb      = b;
    @(negedge clk);
  endtask

  task automatic chkwb(input logic [63:0] d, input logic [1:0] e);
    cmp({63'h0, wb.valid}, 64'h1);
    cmp(wb.data, d);
    cmp({62'h0, exc}, {62'h0, e});
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_store;
    base         = 32'h20001000;
    op.add_off   = 1'h1;
    op.imm_words = 8'hff;
    run(FPSRU_STORE, 1'h0, 3'h0, 64'hdeadbeef11223344, 64'h0);
    cmp({30'h0, st.dbl, st.valid, st.addr}, {30'h0, 2'h1, 32'h200013fc});
    cmp(st.data, 64'h11223344);
    op.add_off   = 1'h0;
    op.imm_words = 8'h3;
    run(FPSRU_STORE, 1'h1, 3'h0, 64'hdeadbeef11223344, 64'h0);
    cmp({30'h0, st.dbl, st.valid, st.addr}, {30'h0, 2'h3, 32'h20000ff4});
    cmp(st.data, 64'hdeadbeef11223344);
    op.add_off   = 1'h1;
    op.imm_words = 8'h0;
    run(FPSRU_STORE, 1'h0, 3'h0, 64'h5, 64'h0);
    cmp({32'h0, st.addr}, {32'h0, base});
    pass = 1'h0;
    run(FPSRU_STORE, 1'h0, 3'h0, 64'h5, 64'h0);
    cmp({63'h0, st.valid}, 64'h0);
    pass = 1'h1;
  endtask

  task automatic t_sub;
    run(FPSRU_SUB, 1'h0, 3'h0, 64'h3fc00000, 64'h3f800000);
    chkwb(64'h3f000000, 2'h0);
    run(FPSRU_SUB, 1'h0, 3'h0, 64'h3f800000, 64'h3f800000);
    chkwb(64'h0, 2'h0);
    run(FPSRU_SUB, 1'h1, 3'h0, 64'h3ff8000000000000, 64'h3ff0000000000000);
    chkwb(64'h3fe0000000000000, 2'h0);
    cmp({63'h0, wb.dbl}, 64'h1);
  endtask

  // Selects are issued as plain ops, never inside a conditional-execution block
  task automatic t_sel;
    logic        h;
    logic        d;
    logic [63:0] e;
    for (int f = 0; f < 16; f++)
      for (int c = 0; c < 4; c++)
      begin
        flg     = 4'(f);
        op.cond = 2'(c);
        case (c)
          0: h = flg.z;
          1: h = flg.v;
          2: h = (flg.n == flg.v);
          default: h = !flg.z && (flg.n == flg.v);
        endcase
        // Odd flag patterns run in double precision
        d = 1'(f);
        e = h ? 64'h3333333311111111 : 64'h4444444422222222;
        run(FPSRU_SEL, d, 3'h0, 64'h3333333311111111, 64'h4444444422222222);
        chkwb(d ? e : {32'h0, e[31:0]}, 2'h0);
      end
  endtask

  task automatic t_mm;
    run(FPSRU_MAXNM, 1'h0, 3'h0, 64'h3f800000, 64'h40000000);
    chkwb(64'h40000000, 2'h0);
    run(FPSRU_MINNM, 1'h0, 3'h0, 64'h3f800000, 64'h40000000);
    chkwb(64'h3f800000, 2'h0);
    run(FPSRU_MAXNM, 1'h0, 3'h0, 64'h7fc00000, 64'h3f800000);
    chkwb(64'h3f800000, 2'h0);
    run(FPSRU_MINNM, 1'h0, 3'h0, 64'h3f800000, 64'h7fc00000);
    chkwb(64'h3f800000, 2'h0);
    run(FPSRU_MAXNM, 1'h0, 3'h0, 64'h7f800001, 64'h3f800000);
    chkwb(64'h7fc00000, 2'h1);
    run(FPSRU_MAXNM, 1'h1, 3'h0, 64'h3ff0000000000000, 64'h4000000000000000);
    chkwb(64'h4000000000000000, 2'h0);
  endtask

  task automatic t_cvt;
    logic [2:0]  rc[4] = '{3'h4, 3'h0, 3'h1, 3'h2};
    logic [31:0] pv[4] = '{32'h3, 32'h2, 32'h3, 32'h2};
    logic [31:0] nv[4] = '{32'hfffffffd, 32'hfffffffe, 32'hfffffffe, 32'hfffffffd};
    op.to_signed = 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      run(FPSRU_CVT, 1'h0, rc[i], 64'h40200000, 64'h0);
      chkwb({32'h0, pv[i]}, 2'h2);
      run(FPSRU_CVT, 1'h1, rc[i], 64'hc004000000000000, 64'h0);
      chkwb({32'h0, nv[i]}, 2'h2);
      cmp({63'h0, wb.dbl}, 64'h0);
    end
    op.to_signed = 1'h0;
    run(FPSRU_CVT, 1'h0, 3'h1, 64'h40200000, 64'h0);
    chkwb(64'h3, 2'h2);
    run(FPSRU_CVT, 1'h0, 3'h0, 64'hc0200000, 64'h0);
    chkwb(64'h0, 2'h1);
  endtask

  task automatic t_rint;
    logic [63:0] rd[5] = '{64'h40000000, 64'h40400000, 64'h40000000, 64'h40000000, 64'h40400000};
    fpm = 2'h0;
    run(FPSRU_RINT_MODE, 1'h0, 3'h1, 64'h40200000, 64'h0);
    chkwb(64'h40000000, 2'h0);
    fpm = 2'h2;
    run(FPSRU_RINT_MODE, 1'h0, 3'h1, 64'h3fc00000, 64'h0);
    chkwb(64'h3f800000, 2'h0);
    fpm = 2'h1;
    run(FPSRU_RINT_EXACT, 1'h0, 3'h0, 64'h40200000, 64'h0);
    chkwb(64'h40400000, 2'h2);
    run(FPSRU_RINT_EXACT, 1'h0, 3'h0, 64'h40000000, 64'h0);
    chkwb(64'h40000000, 2'h0);
    pass = 1'h0;
    for (int m = 0; m < 5; m++)
    begin
      run(FPSRU_RINT_DIR, 1'h0, 3'(m), 64'h40200000, 64'h0);
      chkwb(rd[m], 2'h0);
    end
    pass = 1'h1;
  endtask

  initial
  begin
    #3000000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    clk = 1'h0;
    rst_n = 1'h0;
    op = '0;
    opa = 64'h0;
    opb = 64'h0;
    base = 32'h0;
    flg = '0;
    fpm = 2'h0;
    pass = 1'h1;
    err_total = 0;
    samples_checked = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    t_store();
    t_sub();
    t_sel();
    t_mm();
    t_cvt();
    t_rint();
    cmp({56'h0, nst}, 64'h3);
    report_and_stop();
  end
endmodule
